// >>> ubf_pkg.sv
// Package: register map, field layout, reset values and counts for the baud/FIFO block
`default_nettype none
package ubf_pkg;
    // Register byte addresses on the APB side
    localparam logic [7:0] UBF_ADDR_DATA    = 8'h00;
    localparam logic [7:0] UBF_ADDR_DIV_HI  = 8'h04;
    localparam logic [7:0] UBF_ADDR_DIV_LO  = 8'h08;
    localparam logic [7:0] UBF_ADDR_FCTRL   = 8'h0C;
    localparam logic [7:0] UBF_ADDR_FILL    = 8'h10;
    localparam logic [7:0] UBF_ADDR_CTRL    = 8'h14;
    localparam logic [7:0] UBF_ADDR_STATUS  = 8'h18;
    // Control and status field layout
    localparam int UBF_FC_TRIG_LSB  = 0;
    localparam int UBF_FC_RANGE_BIT = 2;
    localparam int UBF_FC_MOD_LSB   = 3;
    localparam int UBF_CT_ENABLE    = 0;
    localparam int UBF_CT_RIE       = 1;
    localparam int UBF_ST_AVAIL     = 0;
    localparam int UBF_ST_OVERRUN   = 1;
    localparam int UBF_ST_IRQ       = 2;
    localparam int UBF_ST_TXPEND    = 3;
    // Reset values
    localparam logic [7:0] UBF_DIV_RST   = 8'h00;
    localparam logic [5:0] UBF_FCTRL_RST = 6'h00;
    // Sizes
    localparam int UBF_FIFO_DEPTH = 4;
    localparam int UBF_FRAC_W     = 3;
    localparam int UBF_FRAME_BITS = 10;
    localparam int UBF_SHIFT_HOLD = 2;
    // Trigger level codes
    localparam logic [1:0] UBF_TRIG_FULL  = 2'h0;
    localparam logic [1:0] UBF_TRIG_ONE   = 2'h1;
    localparam logic [1:0] UBF_TRIG_TWO   = 2'h2;
    localparam logic [1:0] UBF_TRIG_THREE = 2'h3;
    typedef enum logic [1:0] {
        UBF_RX_IDLE  = 2'b00,
        UBF_RX_START = 2'b01,
        UBF_RX_DATA  = 2'b10,
        UBF_RX_STOP  = 2'b11
    } ubf_rx_state_e;
endpackage
`default_nettype wire

// >>> ubf_mem.sv
// Small byte store for the receive FIFO, registered read data
`default_nettype none
module ubf_mem
    import ubf_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    // Clock
    input  wire  logic             pclk,
    // Write port
    input  wire  logic             wr_en,
    input  wire  logic [AW-1:0]    wr_addr,
    input  wire  logic [WIDTH-1:0] wr_data,
    // Read port
    input  wire  logic [AW-1:0]    rd_addr,
    output logic       [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] store [DEPTH];

    // Storage has no reset; contents are meaningless until written
    always_ff @(posedge pclk) begin
        if (wr_en) begin
            store[wr_addr] <= wr_data;
        end
    end

    // Registered read data
    always_ff @(posedge pclk) begin
        rd_data <= store[rd_addr];
    end
endmodule
`default_nettype wire

// >>> ubf_baud.sv
// Bit-time generator: 16-bit divisor plus 3-bit fractional modulation
`default_nettype none
module ubf_baud
    import ubf_pkg::*;
#(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input  wire  logic             pclk,
    input  wire  logic             presetn,
    // Settings
    input  wire  logic [DIV_W-1:0] divisor,
    input  wire  logic [2:0]       frac_mod,
    input  wire  logic             run,
    input  wire  logic             frame_start,
    // Bit timing
    output logic       [DIV_W-1:0] bit_count,
    output logic                   bit_end
);
    logic [DIV_W-1:0]      cnt_q;
    logic [UBF_FRAC_W-1:0] acc_q;
    logic                  extra_q;
    logic [UBF_FRAC_W:0]   sum;
    logic [DIV_W-1:0]      last;

    assign sum       = {1'b0, acc_q} + {1'b0, frac_mod};
    // Carry lengthens this bit by one clock
    assign last      = extra_q ? divisor : divisor - 16'h0001;
    assign bit_end   = run && (cnt_q >= last);
    assign bit_count = cnt_q;

    // Free-running bit counter, restarts each bit time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (!run || frame_start || bit_end) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    // Fraction accumulator, loaded with frac_mod at each frame start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q   <= '0;
            extra_q <= 1'b0;
        end else if (!run || frame_start) begin
            acc_q   <= frac_mod;
            extra_q <= 1'b0;
        end else if (bit_end) begin
            acc_q   <= sum[UBF_FRAC_W-1:0];
            extra_q <= sum[UBF_FRAC_W];
        end
    end
endmodule
`default_nettype wire

// >>> ubf_top.sv
// Baud generator, receive sampler and four-byte receive FIFO behind APB
`default_nettype none
module ubf_top
    import ubf_pkg::*;
#(
    parameter int DEPTH = UBF_FIFO_DEPTH
) (
    // APB slave
    input  wire  logic        pclk,
    input  wire  logic        presetn,
    input  wire  logic        psel,
    input  wire  logic        penable,
    input  wire  logic        pwrite,
    input  wire  logic [7:0]  paddr,
    input  wire  logic [31:0] pwdata,
    output logic       [31:0] prdata,
    output logic              pready,
    output logic              pslverr,
    // Serial pins
    input  wire  logic        serial_in_pin,
    output logic              serial_out_pin,
    // Interrupt request
    output logic              port_irq
);
    ////////////////////////////////////////////////////////////////////////////
    // Register access
    logic        wr_en;
    logic        rd_en;
    logic        mapped;
    logic [7:0]  div_hi_q;
    logic [7:0]  div_lo_q;
    logic [15:0] divisor_q;
    logic [5:0]  fctrl_q;
    logic        enable_q;
    logic        rie_q;
    logic [7:0]  tx_byte_q;
    logic        tx_pend_q;
    logic        overrun_q;
    logic        avail;

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign mapped  = (paddr == UBF_ADDR_DATA) || (paddr == UBF_ADDR_DIV_HI) ||
                     (paddr == UBF_ADDR_DIV_LO) || (paddr == UBF_ADDR_FCTRL) ||
                     (paddr == UBF_ADDR_FILL) || (paddr == UBF_ADDR_CTRL) ||
                     (paddr == UBF_ADDR_STATUS);
    assign pslverr = psel && penable && !mapped;

    // Divisor bytes; the counter sees a new divisor only on the high write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_hi_q  <= UBF_DIV_RST;
            div_lo_q  <= UBF_DIV_RST;
            divisor_q <= {UBF_DIV_RST, UBF_DIV_RST};
        end else if (wr_en && paddr == UBF_ADDR_DIV_LO) begin
            div_lo_q <= pwdata[7:0];
        end else if (wr_en && paddr == UBF_ADDR_DIV_HI) begin
            div_hi_q  <= pwdata[7:0];
            divisor_q <= {pwdata[7:0], div_lo_q};
        end
    end

    // Control registers survive a port disable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fctrl_q  <= UBF_FCTRL_RST;
            enable_q <= 1'b0;
            rie_q    <= 1'b0;
        end else if (wr_en && paddr == UBF_ADDR_FCTRL) begin
            fctrl_q <= pwdata[5:0];
        end else if (wr_en && paddr == UBF_ADDR_CTRL) begin
            enable_q <= pwdata[UBF_CT_ENABLE];
            rie_q    <= pwdata[UBF_CT_RIE];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Baud timing
    logic        frame_go;
    logic        bit_end;
    logic [15:0] bit_count;
    logic [15:0] half;
    logic        smp_a;
    logic        smp_b;
    logic        smp_c;
    logic        fctrl_range;

    assign fctrl_range = fctrl_q[UBF_FC_RANGE_BIT];
    assign half        = {1'b0, divisor_q[15:1]};

    ubf_baud #(
        .DIV_W(16)
    ) u_baud (
        .pclk       (pclk),
        .presetn    (presetn),
        .divisor    (divisor_q),
        .frac_mod   (fctrl_q[UBF_FC_MOD_LSB +: 3]),
        .run        (enable_q),
        .frame_start(frame_go),
        .bit_count  (bit_count),
        .bit_end    (bit_end)
    );

    // Three sampling points per bit; range select moves the first two, the third is fixed
    assign smp_a = bit_count == (fctrl_range ? half - 16'h0001 : half);
    assign smp_b = bit_count == (fctrl_range ? half : half + 16'h0001);
    assign smp_c = bit_count == half + 16'h0002;

    ////////////////////////////////////////////////////////////////////////////
    // Receiver sampling and frame sequencing
    ubf_rx_state_e rx_st_q;
    logic [3:0]    bit_idx_q;
    logic [1:0]    votes_q;
    logic          vote;
    logic [7:0]    rx_shift_q;
    logic          rx_done;
    logic          tx_busy_q;
    logic [3:0]    tx_idx_q;
    logic [9:0]    tx_frame_q;

    // Two of three samples high; the pin at bit end is not a fourth vote
    assign vote     = votes_q[1];
    assign frame_go = (rx_st_q == UBF_RX_IDLE && enable_q && !serial_in_pin && !tx_busy_q) ||
                      (!tx_busy_q && tx_pend_q && rx_st_q == UBF_RX_IDLE && serial_in_pin);
    assign rx_done  = rx_st_q == UBF_RX_STOP && bit_end;

    // Majority vote over the three samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            votes_q <= 2'h0;
        end else if (bit_end || frame_go) begin
            votes_q <= 2'h0;
        end else if (smp_a || smp_b || smp_c) begin
            if (serial_in_pin) begin
                votes_q <= (votes_q == 2'h0) ? 2'h1 : 2'h2;
            end
        end
    end

    // Receive state machine; one start, eight data, one stop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_q    <= UBF_RX_IDLE;
            bit_idx_q  <= 4'h0;
            rx_shift_q <= 8'h00;
        end else if (!enable_q) begin
            rx_st_q   <= UBF_RX_IDLE;
            bit_idx_q <= 4'h0;
        end else begin
            case (rx_st_q)
                UBF_RX_IDLE: begin
                    if (!serial_in_pin && !tx_busy_q) begin
                        rx_st_q <= UBF_RX_START;
                    end
                end
                UBF_RX_START: begin
                    if (bit_end) begin
                        rx_st_q   <= vote ? UBF_RX_IDLE : UBF_RX_DATA;
                        bit_idx_q <= 4'h0;
                    end
                end
                UBF_RX_DATA: begin
                    if (bit_end) begin
                        rx_shift_q <= {vote, rx_shift_q[7:1]};
                        bit_idx_q  <= bit_idx_q + 4'h1;
                        if (bit_idx_q == 4'h7) begin
                            rx_st_q <= UBF_RX_STOP;
                        end
                    end
                end
                UBF_RX_STOP: begin
                    if (bit_end) begin
                        rx_st_q <= UBF_RX_IDLE;
                    end
                end
                default: rx_st_q <= UBF_RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit path; data register write is the serial output byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_byte_q <= 8'h00;
            tx_pend_q <= 1'b0;
        end else if (!enable_q) begin
            tx_pend_q <= 1'b0;
        end else if (wr_en && paddr == UBF_ADDR_DATA) begin
            tx_byte_q <= pwdata[7:0];
            tx_pend_q <= 1'b1;
        end else if (frame_go && tx_pend_q && serial_in_pin) begin
            tx_pend_q <= 1'b0;
        end
    end

    // Shift out LSB first; idle line is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_busy_q  <= 1'b0;
            tx_idx_q   <= 4'h0;
            tx_frame_q <= 10'h3FF;
        end else if (!enable_q) begin
            tx_busy_q  <= 1'b0;
            tx_frame_q <= 10'h3FF;
        end else if (!tx_busy_q && tx_pend_q && rx_st_q == UBF_RX_IDLE && serial_in_pin) begin
            tx_busy_q  <= 1'b1;
            tx_idx_q   <= 4'h0;
            tx_frame_q <= {1'b1, tx_byte_q, 1'b0};
        end else if (tx_busy_q && bit_end) begin
            tx_frame_q <= {1'b1, tx_frame_q[9:1]};
            tx_idx_q   <= tx_idx_q + 4'h1;
            if (tx_idx_q == 4'(UBF_FRAME_BITS - 1)) begin
                tx_busy_q <= 1'b0;
            end
        end
    end
    assign serial_out_pin = tx_frame_q[0];

    ////////////////////////////////////////////////////////////////////////////
    // Receive FIFO with two shift-stage holding slots beyond it
    logic [1:0] wptr_q;
    logic [1:0] rptr_q;
    logic [2:0] fill_q;
    logic [1:0] hold_cnt_q;
    logic [7:0] hold_q [UBF_SHIFT_HOLD];
    logic       pop;
    logic       push;
    logic [7:0] push_data;
    logic [7:0] mem_rd;

    assign pop       = rd_en && paddr == UBF_ADDR_DATA && fill_q != 3'h0;
    // A byte landing while a full FIFO is read with the holding stage empty takes the slot the read frees
    assign push      = (rx_done && (fill_q != 3'(DEPTH) || (pop && hold_cnt_q == 2'h0))) ||
                       (pop && hold_cnt_q != 2'h0);
    assign push_data = (hold_cnt_q != 2'h0) ? hold_q[0] : rx_shift_q;

    ubf_mem #(
        .WIDTH(8),
        .DEPTH(DEPTH),
        .AW   (2)
    ) u_mem (
        .pclk   (pclk),
        .wr_en  (push),
        .wr_addr(wptr_q),
        .wr_data(push_data),
        .rd_addr(pop ? rptr_q + 2'h1 : rptr_q),
        .rd_data(mem_rd)
    );

    // Pointers and fill count; enable low empties everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_q <= 2'h0;
            rptr_q <= 2'h0;
            fill_q <= 3'h0;
        end else if (!enable_q || (wr_en && paddr == UBF_ADDR_CTRL && pwdata[UBF_CT_ENABLE])) begin
            wptr_q <= 2'h0;
            rptr_q <= 2'h0;
            fill_q <= 3'h0;
        end else begin
            if (push) begin
                wptr_q <= wptr_q + 2'h1;
            end
            if (pop) begin
                rptr_q <= rptr_q + 2'h1;
            end
            if (push && !pop) begin
                fill_q <= fill_q + 3'h1;
            end else if (pop && !push) begin
                fill_q <= fill_q - 3'h1;
            end
        end
    end

    // Overflow bytes wait in the shift stage; count stays at four
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt_q <= 2'h0;
            hold_q[0]  <= 8'h00;
            hold_q[1]  <= 8'h00;
            overrun_q  <= 1'b0;
        end else if (!enable_q) begin
            hold_cnt_q <= 2'h0;
            overrun_q  <= 1'b0;
        end else if (rx_done && fill_q == 3'(DEPTH) && !pop) begin
            if (hold_cnt_q == 2'(UBF_SHIFT_HOLD)) begin
                overrun_q <= 1'b1;
            end else begin
                hold_q[hold_cnt_q[0]] <= rx_shift_q;
                hold_cnt_q            <= hold_cnt_q + 2'h1;
            end
        end else if (pop && hold_cnt_q != 2'h0) begin
            hold_q[0] <= hold_q[1];
            // New byte refills the stage the read just drained
            if (rx_done) begin
                hold_q[hold_cnt_q[1]] <= rx_shift_q;
            end else begin
                hold_cnt_q <= hold_cnt_q - 2'h1;
            end
        end else if (rd_en && paddr == UBF_ADDR_STATUS) begin
            overrun_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger level and interrupt request
    always_comb begin
        case (fctrl_q[UBF_FC_TRIG_LSB +: 2])
            UBF_TRIG_FULL:  avail = fill_q == 3'(DEPTH);
            UBF_TRIG_ONE:   avail = fill_q >= 3'h1;
            UBF_TRIG_TWO:   avail = fill_q >= 3'h2;
            UBF_TRIG_THREE: avail = fill_q >= 3'h3;
            default:        avail = 1'b0;
        endcase
    end
    assign port_irq = rie_q && (avail || overrun_q);

    ////////////////////////////////////////////////////////////////////////////
    // Read data, unimplemented bits read zero; fill count ignores writes
    always_comb begin
        prdata = 32'h0000_0000;
        case (paddr)
            UBF_ADDR_DATA:   prdata[7:0] = mem_rd;
            UBF_ADDR_DIV_HI: prdata[7:0] = div_hi_q;
            UBF_ADDR_DIV_LO: prdata[7:0] = div_lo_q;
            UBF_ADDR_FCTRL:  prdata[5:0] = fctrl_q;
            UBF_ADDR_FILL:   prdata[2:0] = fill_q;
            UBF_ADDR_CTRL:   prdata[1:0] = {rie_q, enable_q};
            UBF_ADDR_STATUS: prdata[3:0] = {tx_pend_q, port_irq, overrun_q, avail};
            default:         prdata = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_fill_max;
        @(posedge pclk) disable iff (!presetn) fill_q <= 3'(DEPTH);
    endproperty
    a_fill_max: assert property (p_fill_max) else $error("fill count above four");

    property p_disable_clears;
        @(posedge pclk) disable iff (!presetn) !enable_q |=> fill_q == 3'h0;
    endproperty
    a_disable_clears: assert property (p_disable_clears) else $error("fill not cleared");

    property p_irq_gate;
        @(posedge pclk) disable iff (!presetn) !rie_q |-> !port_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

    property p_irq_avail;
        @(posedge pclk) disable iff (!presetn) (rie_q && avail) |-> port_irq;
    endproperty
    a_irq_avail: assert property (p_irq_avail) else $error("irq missing");

    property p_push_count;
        @(posedge pclk) disable iff (!presetn)
            (enable_q && push && !pop && !wr_en) |=> fill_q == $past(fill_q) + 3'h1;
    endproperty
    a_push_count: assert property (p_push_count) else $error("count not incremented");

    property p_pop_count;
        @(posedge pclk) disable iff (!presetn)
            (enable_q && pop && !push) |=> fill_q == $past(fill_q) - 3'h1;
    endproperty
    a_pop_count: assert property (p_pop_count) else $error("count not decremented");

    property p_lo_pending;
        @(posedge pclk) disable iff (!presetn)
            (wr_en && paddr == UBF_ADDR_DIV_LO) |=> $stable(divisor_q);
    endproperty
    a_lo_pending: assert property (p_lo_pending) else $error("divisor moved on low write");

    property p_full_trig;
        @(posedge pclk) disable iff (!presetn)
            (fctrl_q[1:0] == UBF_TRIG_FULL && fill_q != 3'(DEPTH)) |-> !avail;
    endproperty
    a_full_trig: assert property (p_full_trig) else $error("flag early at level 00");
endmodule
`default_nettype wire

// >>> ubf_remote.sv
// Remote serial transmitter model that drives the block's receive pin
`default_nettype none
module ubf_remote (
    // Clock
    input  wire logic pclk,
    // Line toward the block
    output logic      serial_in_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int bit_cycles = 16;
    // Line idles high between frames, as a pulled-up wire would
    initial serial_in_pin = 1'b1;
    // One 8N1 frame, least significant bit first; changes just after an edge
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            serial_in_pin <= f[i];
            repeat (bit_cycles) @(posedge pclk);
        end
    endtask
endmodule
`default_nettype wire

// >>> uart_baud_fifo_control_test.sv
// Self-checking bench for the baud generator and receive FIFO block
`default_nettype none
module uart_baud_fifo_control_test
    import ubf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
    logic        serial_in_pin, serial_out_pin, port_irq, av, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    int          err_count, cmp_count, cyc;
    ////////////////////////////////////////////////////////////////////////
    ubf_top u_ubf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .port_irq(port_irq));
    ubf_remote u_ubf_remote (.pclk(pclk), .serial_in_pin(serial_in_pin));
    // 10 MHz clock
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Hang guard, well above the expected run length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen high, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string what);
        apb(1'b0, a, 32'h0);
        chk(rd, e, what);
    endtask
    // Remote sends a byte; a few cycles let it land in the FIFO
    task automatic rx(input logic [7:0] v);
        u_ubf_remote.send(v);
        repeat (4) @(posedge pclk);
    endtask
    // Write a byte and sample the outgoing frame mid-bit
    task automatic txchk(input logic [7:0] v);
        logic [9:0] f;
        int n;
        wr(UBF_ADDR_DATA, {24'h0, v});
        n = 0;
        while (serial_out_pin !== 1'b0 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        repeat (8) @(posedge pclk);
        for (int i = 0; i < 10; i++) begin
            f[i] = serial_out_pin;
            repeat (16) @(posedge pclk);
        end
        chk({22'h0, f}, {22'h0, 1'b1, v, 1'b0}, "tx frame");
    endtask
    // Send 0x55 at divisor 16 so every bit edge shows; time the start and eight data bits by the fraction rule
    task automatic fracchk(input logic [2:0] m);
        int   acc;
        int   len;
        logic b;
        wr(UBF_ADDR_FCTRL, {26'h0, m, 3'h7});
        wr(UBF_ADDR_DATA, 32'h55);
        while (serial_out_pin !== 1'b0) begin
            @(posedge pclk);
        end
        acc = 0;
        for (int i = 0; i < 9; i++) begin
            b = serial_out_pin;
            len = 0;
            do begin
                @(posedge pclk);
                len++;
            end while (serial_out_pin === b);
            acc = acc + m;
            chk(len, 16 + acc / 8, "bit time");
            acc = acc % 8;
        end
        repeat (24) @(posedge pclk);
        wr(UBF_ADDR_FCTRL, 32'h07);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        err_count = 0;
        cmp_count = 0;
        cyc = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, unused bits, read-only count, unmapped place
        rchk(UBF_ADDR_DIV_HI, 32'h0, "div hi reset");
        rchk(UBF_ADDR_DIV_LO, 32'h0, "div lo reset");
        rchk(UBF_ADDR_FILL, 32'h0, "fill reset");
        wr(UBF_ADDR_FCTRL, 32'hFF);
        rchk(UBF_ADDR_FCTRL, 32'h3F, "fctrl upper");
        wr(UBF_ADDR_FILL, 32'hFF);
        rchk(UBF_ADDR_FILL, 32'h0, "fill write");
        rchk(8'h40, 32'h0, "unmapped");
        chk({31'h0, slv}, 32'h1, "slverr");
        $display("test registers done");
        // Every trigger code, both range settings, mask on and off
        wr(UBF_ADDR_DIV_LO, 32'h10);
        wr(UBF_ADDR_DIV_HI, 32'h00);
        for (int t = 0; t < 4; t++) begin
            wr(UBF_ADDR_CTRL, 32'h0);
            wr(UBF_ADDR_FCTRL, {29'h0, t[1], t[1:0]});
            wr(UBF_ADDR_CTRL, {30'h0, t[0], 1'b1});
            for (int k = 1; k <= 4; k++) begin
                rx(8'h30 + k[7:0]);
                av = (k >= ((t == 0) ? 4 : t));
                irq = t[0] & av;
                rchk(UBF_ADDR_FILL, k, "fill");
                rchk(UBF_ADDR_STATUS, {29'h0, irq, 1'b0, av}, "status");
                chk({31'h0, port_irq}, {31'h0, irq}, "irq pin");
            end
        end
        $display("test trigger levels done");
        // Full FIFO: two more bytes wait, count stays at four, a seventh overruns
        rx(8'h35);
        rx(8'h36);
        rchk(UBF_ADDR_FILL, 32'h4, "fill full");
        rx(8'h37);
        rchk(UBF_ADDR_STATUS, 32'h7, "overrun");
        for (int k = 1; k <= 6; k++) begin
            rchk(UBF_ADDR_DATA, 8'h30 + k[7:0], "data order");
        end
        rchk(UBF_ADDR_FILL, 32'h0, "fill drained");
        $display("test overflow done");
        // Enable write clears the count; disable empties the FIFO but keeps settings
        rx(8'h77);
        wr(UBF_ADDR_CTRL, 32'h1);
        rchk(UBF_ADDR_FILL, 32'h0, "fill enable write");
        rx(8'h77);
        wr(UBF_ADDR_CTRL, 32'h0);
        rchk(UBF_ADDR_FILL, 32'h0, "fill disabled");
        rchk(UBF_ADDR_DIV_LO, 32'h10, "div kept");
        rchk(UBF_ADDR_FCTRL, 32'h07, "fctrl kept");
        wr(UBF_ADDR_CTRL, 32'h1);
        txchk(8'h5A);
        fracchk(3'h3);
        $display("test disable and transmit done");
        // Low byte alone leaves the old divisor in force
        wr(UBF_ADDR_DIV_LO, 32'h20);
        rx(8'h5C);
        rchk(UBF_ADDR_DATA, 32'h5C, "low pending");
        wr(UBF_ADDR_DIV_HI, 32'h00);
        u_ubf_remote.bit_cycles = 32;
        rx(8'hC3);
        rchk(UBF_ADDR_DATA, 32'hC3, "new divisor");
        $display("test divisor load done");
        finish_test();
    end
endmodule
`default_nettype wire
